// file: verilog/tha_device.sv
// Touch controller end: bus slave with report memory and attention line logic.
// Assumes a scanning core beside it that writes report bytes and flags scans.
//
// The plain strobed port and the register offsets were left to the implementer.
`default_nettype none

module tha_device #(
  parameter longint TMO_CYC = tha_pkg::BYTE_TMO_CYC
) (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_srst,
  // Link
  tha_link_if.device      link,
  // Scanning core
  input  wire logic       i_scan_done,
  input  wire logic       i_finger,
  input  wire logic       i_core_busy,
  input  wire logic       i_sleep,
  input  wire logic       i_rpt_wr,
  input  wire logic [5:0] i_rpt_addr,
  input  wire logic [7:0] i_rpt_data,
  // Status to core
  output logic            o_wake,
  output logic            o_slow_scan
);
  // Byte timer is 32 bits wide and must count at least once
  if (TMO_CYC < 1 || TMO_CYC > 64'hFFFFFFFF) begin : g_bad_tmo
    $error("byte timeout count out of range");
  end

  typedef enum logic [2:0] {
    SL_IDLE = 3'b000,
    SL_RX   = 3'b001,
    SL_ACK  = 3'b011,
    SL_TX   = 3'b010,
    SL_RACK = 3'b110
  } tha_sl_state_type;

  // ==========================================================================
  // Pin synchronisers, three stages, change taken when last two agree
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic       scl_q;
  logic       sda_q;
  logic       scl_prev_q;
  logic       sda_prev_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], link.scl};
      sda_sync_q <= {sda_sync_q[1:0], link.sda};
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2]) begin
        sda_q <= sda_sync_q[2];
      end
      scl_prev_q <= scl_q;
      sda_prev_q <= sda_q;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise   = scl_q & ~scl_prev_q;
  assign scl_fall   = ~scl_q & scl_prev_q;
  assign start_cond = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
  assign stop_cond  = scl_q & scl_prev_q & ~sda_prev_q & sda_q;

  // ==========================================================================
  // Slave byte engine
  tha_sl_state_type state_q;
  logic [7:0]       shift_q;
  logic [3:0]       bit_q;
  logic             rd_q;
  logic             addr_phase_q;
  logic             ptr_phase_q;
  logic [5:0]       ptr_q;
  logic             sda_low_q;
  logic             zero_rd_q;
  logic [31:0]      tmo_q;
  logic [7:0]       mem_q [64];
  logic             tmo_hit;
  logic [7:0]       rx_byte;
  logic             wr_byte;

  assign tmo_hit = (state_q != SL_IDLE) && (64'(tmo_q) >= 64'(TMO_CYC));
  assign rx_byte = {shift_q[6:0], sda_q};
  assign wr_byte = (state_q == SL_RX) && scl_fall && (bit_q == 4'h8)
                   && !addr_phase_q && !ptr_phase_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst || stop_cond || tmo_hit) begin
      state_q   <= SL_IDLE;
      sda_low_q <= 1'b0;
      bit_q     <= 4'h0;
    end else if (start_cond) begin
      state_q      <= SL_RX;
      bit_q        <= 4'h0;
      addr_phase_q <= 1'b1;
      ptr_phase_q  <= 1'b0;
      sda_low_q    <= 1'b0;
    end else begin
      unique case (state_q)
        SL_IDLE: begin
        end
        SL_RX: begin
          if (scl_rise) begin
            shift_q <= rx_byte;
            bit_q   <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            if (addr_phase_q) begin
              // Seven-bit match only; a ten-bit prefix never matches
              if (shift_q[7:1] == tha_pkg::SLAVE_ADDR) begin
                state_q   <= SL_ACK;
                sda_low_q <= 1'b1;
                rd_q      <= shift_q[0];
                ptr_phase_q <= ~shift_q[0];
              end else begin
                state_q <= SL_IDLE;
              end
            end else begin
              state_q   <= SL_ACK;
              sda_low_q <= 1'b1;
            end
          end
        end
        SL_ACK: begin
          if (scl_fall) begin
            bit_q <= 4'h0;
            addr_phase_q <= 1'b0;
            if (!addr_phase_q) begin
              ptr_phase_q <= 1'b0;
            end
            if (rd_q) begin
              state_q   <= SL_TX;
              shift_q   <= mem_q[ptr_q];
              sda_low_q <= ~mem_q[ptr_q][7];
            end else begin
              state_q   <= SL_RX;
              sda_low_q <= 1'b0;
            end
          end
        end
        SL_TX: begin
          if (scl_fall) begin
            bit_q     <= bit_q + 4'h1;
            shift_q   <= {shift_q[6:0], 1'b0};
            sda_low_q <= (bit_q == 4'h7) ? 1'b0 : ~shift_q[6];
            if (bit_q == 4'h7) begin
              state_q <= SL_RACK;
            end
          end
        end
        SL_RACK: begin
          if (scl_rise) begin
            rd_q <= ~sda_q;
          end else if (scl_fall) begin
            bit_q <= 4'h0;
            if (rd_q) begin
              state_q   <= SL_TX;
              shift_q   <= mem_q[ptr_q];
              sda_low_q <= ~mem_q[ptr_q][7];
            end else begin
              state_q <= SL_IDLE;
            end
          end
        end
        default: state_q <= SL_IDLE;
      endcase
    end
  end

  // Pointer: set by first written byte, advances after each data byte
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ptr_q <= 6'h00;
    end else if (state_q == SL_RX && scl_fall && bit_q == 4'h8 && ptr_phase_q) begin
      ptr_q <= shift_q[5:0];
    end else if (wr_byte || (state_q == SL_TX && scl_fall && bit_q == 4'h7)) begin
      ptr_q <= ptr_q + 6'h01;
    end
  end

  // Byte timer restarts on every finished byte and on start
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || state_q == SL_IDLE || start_cond || (scl_fall && bit_q == 4'h8)
        || (state_q == SL_RACK && scl_fall)) begin
      tmo_q <= 32'h0;
    end else begin
      tmo_q <= tmo_q + 32'h1;
    end
  end

  // ==========================================================================
  // Report memory: core writes report, host writes only configuration
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      for (int i = 0; i < 64; i++) begin
        mem_q[i] <= 8'h00;
      end
      mem_q[tha_pkg::REG_ATTN_MODE]  <= tha_pkg::ATTN_MODE_RST;
      mem_q[tha_pkg::REG_ATTN_WIDTH] <= tha_pkg::ATTN_WIDTH_RST;
    end else if (i_rpt_wr) begin
      mem_q[i_rpt_addr] <= i_rpt_data;
    end else if (wr_byte && ptr_q >= tha_pkg::REG_CFG_FIRST) begin
      mem_q[ptr_q] <= shift_q;
    end
  end

  // ==========================================================================
  // Service detection: zero-finger status byte sent, then stop
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || start_cond) begin
      zero_rd_q <= 1'b0;
    end else if (state_q == SL_ACK && scl_fall && rd_q && ptr_q == tha_pkg::REG_TOUCHING
                 && mem_q[tha_pkg::REG_TOUCHING][tha_pkg::NFING_MSB:0] == 3'h0) begin
      zero_rd_q <= 1'b1;
    end
  end

  logic serviced;
  assign serviced = stop_cond & zero_rd_q;

  // Wake when own address seen while asleep; engine runs on either state
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= i_sleep && state_q == SL_RX && addr_phase_q && scl_fall && bit_q == 4'h8
                && shift_q[7:1] == tha_pkg::SLAVE_ADDR;
    end
  end

  // ==========================================================================
  // Attention logic
  tha_pkg::tha_attn_mode_type mode;
  logic       pol;
  logic       pend_q;
  logic [7:0] units_q;
  logic [6:0] sub_q;
  logic       pulse_q;
  logic       fire;

  assign mode = tha_pkg::tha_attn_mode_type'(mem_q[tha_pkg::REG_ATTN_MODE][1:0]);
  assign pol  = mem_q[tha_pkg::REG_ATTN_MODE][tha_pkg::POL_BIT];

  // Touch pending until a lifted state is serviced; set wins over clear
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      pend_q <= 1'b0;
    end else if (i_scan_done && i_finger) begin
      pend_q <= 1'b1;
    end else if (serviced && !i_finger) begin
      pend_q <= 1'b0;
    end
  end

  always_comb begin
    unique case (mode)
      tha_pkg::ATTN_EVERY_SCAN: fire = i_scan_done;
      tha_pkg::ATTN_PULSE_MOVE: fire = i_scan_done && (i_finger || pend_q);
      tha_pkg::ATTN_LEVEL:      fire = 1'b0;
      tha_pkg::ATTN_PULSE_HOLD: fire = i_scan_done && (i_finger || pend_q);
    endcase
  end

  // Pulse of width units, one unit of a microsecond, zero taken as one
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      pulse_q <= 1'b0;
      units_q <= 8'h00;
      sub_q   <= 7'h00;
    end else if (fire) begin
      pulse_q <= 1'b1;
      units_q <= mem_q[tha_pkg::REG_ATTN_WIDTH];
      sub_q   <= 7'(tha_pkg::ATTN_UNIT_CYC - 1);
    end else if (pulse_q) begin
      if (sub_q != 7'h00) begin
        sub_q <= sub_q - 7'h01;
      end else if (units_q > 8'h01) begin
        units_q <= units_q - 8'h01;
        sub_q   <= 7'(tha_pkg::ATTN_UNIT_CYC - 1);
      end else begin
        pulse_q <= 1'b0;
      end
    end
  end

  logic asserted;
  assign asserted = (mode == tha_pkg::ATTN_LEVEL) ? (i_finger || pend_q) : pulse_q;

  // Attention level from a flop, idle at the reset polarity
  logic attn_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      attn_q <= ~tha_pkg::ATTN_MODE_RST[tha_pkg::POL_BIT];
    end else begin
      attn_q <= pol ? asserted : ~asserted;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_slow_scan <= 1'b0;
    end else begin
      o_slow_scan <= (mode != tha_pkg::ATTN_EVERY_SCAN) && !pend_q && !i_finger;
    end
  end

  // ==========================================================================
  // Pin drive: all undriven while reset holds
  logic drive_q;
  always_ff @(posedge i_ref_clk) begin
    drive_q <= ~i_srst;
  end

  assign link.dev_scl_o   = 1'b0;
  assign link.dev_sda_o   = 1'b0;
  // Stretch only in a low phase, so the stretch never forces a false edge
  assign link.dev_scl_oe  = drive_q && i_core_busy && !scl_q && state_q != SL_IDLE;
  assign link.dev_sda_oe  = drive_q && sda_low_q;
  assign link.dev_attn_o  = attn_q;
  assign link.dev_attn_oe = drive_q;
endmodule

`default_nettype wire

// file: verilog/tha_pkg.sv
// Shared constants of the touch host link: bus timing, device map, host command map.
// Assumes a 100 MHz system clock on both ends.
`default_nettype none

package tha_pkg;
  // ==========================================================================
  // Clock and link timing
  localparam int unsigned CLK_NS         = 10;
  localparam int unsigned BUS_MAX_HZ     = 400000;
  localparam int unsigned BIT_NS         = 1000000000 / BUS_MAX_HZ;
  localparam int unsigned QTR_CYC        = (BIT_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
  localparam int unsigned BYTE_TMO_MS    = 100;
  localparam longint     BYTE_TMO_CYC   = (64'(BYTE_TMO_MS) * 64'd1000000) / 64'(CLK_NS);
  localparam int unsigned ATTN_UNIT_NS   = 1000;
  localparam int unsigned ATTN_UNIT_CYC  = ATTN_UNIT_NS / CLK_NS;

  // ==========================================================================
  // Device side
  localparam logic [6:0] SLAVE_ADDR      = 7'h5C;
  localparam logic [5:0] REG_TOUCHING    = 6'h00;
  localparam logic [5:0] REG_CFG_FIRST   = 6'h33;
  localparam logic [5:0] REG_ATTN_MODE   = 6'h34;
  localparam logic [5:0] REG_ATTN_WIDTH  = 6'h35;
  localparam logic [7:0] ATTN_MODE_RST   = 8'h00;
  localparam logic [7:0] ATTN_WIDTH_RST  = 8'h0A;
  localparam int unsigned POL_BIT        = 2;
  localparam int unsigned NFING_MSB      = 2;

  typedef enum logic [1:0] {
    ATTN_EVERY_SCAN = 2'b00,
    ATTN_PULSE_MOVE = 2'b01,
    ATTN_LEVEL      = 2'b10,
    ATTN_PULSE_HOLD = 2'b11
  } tha_attn_mode_type;

  // ==========================================================================
  // Host command registers
  localparam logic [4:0] HREG_CTRL       = 5'h00;
  localparam logic [4:0] HREG_PTR        = 5'h04;
  localparam logic [4:0] HREG_WDATA      = 5'h08;
  localparam logic [4:0] HREG_RDATA      = 5'h0C;
  localparam logic [4:0] HREG_STATUS     = 5'h10;
  localparam logic [4:0] HREG_IRQ_STAT   = 5'h14;
  localparam logic [4:0] HREG_IRQ_MASK   = 5'h18;
  localparam logic [4:0] HREG_CFG        = 5'h1C;
  localparam int unsigned IRQ_DONE       = 0;
  localparam int unsigned IRQ_NACK       = 1;
  localparam int unsigned IRQ_ATTN       = 2;
endpackage

`default_nettype wire

// file: verilog/tha_link_if.sv
// Three-wire link: open-drain clock and data pair plus the attention line.
// Assumes external pull-ups: an undriven wire reads high.
`default_nettype none

interface tha_link_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic dev_attn_o;
  logic dev_attn_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic scl;
  logic sda;
  logic attn;

  // Wired-AND of both open-drain drivers
  assign scl  = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o));
  assign sda  = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));
  assign attn = dev_attn_oe ? dev_attn_o : 1'b1;

  modport device (
    input  scl, sda,
    output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe, dev_attn_o, dev_attn_oe
  );
  modport host (
    input  scl, sda, attn,
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe
  );
endinterface

`default_nettype wire

// file: verilog/tha_host.sv
// Host end: bus master driven by a simple register port, with interrupt logic.
// Assumes the device end on the other side of the link interface.
`default_nettype none

module tha_host (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_srst,
  // Register port
  input  wire logic [4:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Interrupt
  output logic            o_irq,
  // Link
  tha_link_if.host        link
);
  typedef enum logic [1:0] {
    SY_START = 2'b00,
    SY_BIT   = 2'b01,
    SY_STOP  = 2'b11,
    SY_IDLE  = 2'b10
  } tha_sym_type;

  // ==========================================================================
  // Synchronisers for pins from the link
  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic [2:0] att_s_q;
  logic       scl_q;
  logic       sda_q;
  logic       att_q;
  logic       att_prev_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      {scl_s_q, sda_s_q, att_s_q} <= 9'h1FF;
      {scl_q, sda_q, att_q, att_prev_q} <= 4'hF;
    end else begin
      scl_s_q <= {scl_s_q[1:0], link.scl};
      sda_s_q <= {sda_s_q[1:0], link.sda};
      att_s_q <= {att_s_q[1:0], link.attn};
      if (scl_s_q[1] == scl_s_q[2]) scl_q <= scl_s_q[2];
      if (sda_s_q[1] == sda_s_q[2]) sda_q <= sda_s_q[2];
      if (att_s_q[1] == att_s_q[2]) att_q <= att_s_q[2];
      att_prev_q <= att_q;
    end
  end

  // ==========================================================================
  // Registers
  logic [7:0] ptr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic       att_pol_q;
  logic       go;
  logic       busy_q;
  logic       dir_q;
  logic       nack_q;
  logic       done_ev;
  logic       att_ev;
  assign go     = i_wr && i_addr == tha_pkg::HREG_CTRL && i_wdata[0] && !busy_q;
  assign att_ev = (att_q == att_pol_q) && (att_prev_q != att_pol_q);

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ptr_q      <= 8'h00;
      wdata_q    <= 8'h00;
      irq_mask_q <= 3'h0;
      att_pol_q  <= 1'b0;
      dir_q      <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == tha_pkg::HREG_PTR)      ptr_q      <= i_wdata;
      if (i_addr == tha_pkg::HREG_WDATA)    wdata_q    <= i_wdata;
      if (i_addr == tha_pkg::HREG_IRQ_MASK) irq_mask_q <= i_wdata[2:0];
      if (i_addr == tha_pkg::HREG_CFG)      att_pol_q  <= i_wdata[0];
      if (go)                               dir_q      <= i_wdata[1];
    end
  end

  // Sticky events, set wins over write-one clear
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      irq_stat_q <= 3'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((i_wr && i_addr == tha_pkg::HREG_IRQ_STAT)
                                    ? i_wdata[2:0] : 3'h0))
                    | {att_ev, done_ev & nack_q, done_ev};
    end
  end
  assign o_irq = |(irq_stat_q & irq_mask_q);

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        tha_pkg::HREG_PTR:      o_rdata <= ptr_q;
        tha_pkg::HREG_WDATA:    o_rdata <= wdata_q;
        tha_pkg::HREG_RDATA:    o_rdata <= rdata_q;
        tha_pkg::HREG_STATUS:   o_rdata <= {5'h00, att_q == att_pol_q, nack_q, busy_q};
        tha_pkg::HREG_IRQ_STAT: o_rdata <= {5'h00, irq_stat_q};
        tha_pkg::HREG_IRQ_MASK: o_rdata <= {5'h00, irq_mask_q};
        tha_pkg::HREG_CFG:      o_rdata <= {7'h00, att_pol_q};
        default:                o_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Transfer sequencer; write: S A P D P, read: S A P S A' R P
  logic [6:0]  div_q;
  logic        qtick;
  logic [1:0]  ph_q;
  logic [3:0]  bit_q;
  logic [2:0]  step_q;
  logic [7:0]  tx_q;
  logic        scl_low_q;
  logic        sda_low_q;
  tha_sym_type sym;
  logic [7:0]  step_byte;
  logic        last_step;
  logic        rd_byte;

  assign qtick = div_q == 7'(tha_pkg::QTR_CYC - 1);
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || qtick || !busy_q) div_q <= 7'h00;
    else                            div_q <= div_q + 7'h01;
  end

  always_comb begin
    sym       = SY_BIT;
    step_byte = 8'hFF;
    rd_byte   = 1'b0;
    last_step = 1'b0;
    unique case (step_q)
      3'h0: sym = SY_START;
      3'h1: step_byte = {tha_pkg::SLAVE_ADDR, 1'b0};
      3'h2: step_byte = ptr_q;
      3'h3: begin
        if (dir_q) sym = SY_START;
        else       step_byte = wdata_q;
      end
      3'h4: begin
        if (dir_q) step_byte = {tha_pkg::SLAVE_ADDR, 1'b1};
        else       sym = SY_STOP;
        last_step = !dir_q;
      end
      3'h5: rd_byte = 1'b1;
      3'h6: begin
        sym       = SY_STOP;
        last_step = 1'b1;
      end
      default: sym = SY_IDLE;
    endcase
  end

  assign done_ev = busy_q && qtick && ph_q == 2'h3 && last_step;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      busy_q    <= 1'b0;
      nack_q    <= 1'b0;
      ph_q      <= 2'h0;
      bit_q     <= 4'h0;
      step_q    <= 3'h0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      rdata_q   <= 8'h00;
      tx_q      <= 8'h00;
    end else if (go) begin
      busy_q <= 1'b1;
      nack_q <= 1'b0;
      ph_q   <= 2'h0;
      bit_q  <= 4'h0;
      step_q <= 3'h0;
    end else if (busy_q && qtick && !(ph_q == 2'h2 && !scl_q)) begin
      // Sampling phase waits until the released clock reads high
      ph_q <= ph_q + 2'h1;
      unique case (sym)
        SY_START: begin
          if (ph_q == 2'h0) sda_low_q <= 1'b0;
          if (ph_q == 2'h1) scl_low_q <= 1'b0;
          if (ph_q == 2'h2) sda_low_q <= 1'b1;
          if (ph_q == 2'h3) begin
            scl_low_q <= 1'b1;
            step_q    <= step_q + 3'h1;
          end
        end
        SY_BIT: begin
          if (ph_q == 2'h0) begin
            scl_low_q <= 1'b1;
            if (bit_q == 4'h0 && !rd_byte) begin
              sda_low_q <= ~step_byte[7];
              tx_q      <= {step_byte[6:0], 1'b0};
            end else if (bit_q < 4'h8 && !rd_byte) begin
              sda_low_q <= ~tx_q[7];
              tx_q      <= {tx_q[6:0], 1'b0};
            end else begin
              // Read bits float; final read answered with no-acknowledge
              sda_low_q <= (bit_q == 4'h8) ? 1'b0 : (bit_q == 4'h8 && !rd_byte);
            end
          end
          if (ph_q == 2'h1) scl_low_q <= 1'b0;
          if (ph_q == 2'h2) begin
            if (bit_q == 4'h8 && !rd_byte && sda_q) nack_q <= 1'b1;
            if (bit_q < 4'h8 && rd_byte) rdata_q <= {rdata_q[6:0], sda_q};
          end
          if (ph_q == 2'h3) begin
            scl_low_q <= 1'b1;
            bit_q     <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
            if (bit_q == 4'h8) begin
              step_q <= (!rd_byte && sda_q) ? (dir_q ? 3'h6 : 3'h4) : step_q + 3'h1;
            end
          end
        end
        SY_STOP: begin
          if (ph_q == 2'h0) begin
            scl_low_q <= 1'b1;
            sda_low_q <= 1'b1;
          end
          if (ph_q == 2'h1) scl_low_q <= 1'b0;
          if (ph_q == 2'h2) sda_low_q <= 1'b0;
          if (ph_q == 2'h3) busy_q <= 1'b0;
        end
        SY_IDLE: busy_q <= 1'b0;
      endcase
    end
  end

  assign link.host_scl_o  = 1'b0;
  assign link.host_sda_o  = 1'b0;
  assign link.host_scl_oe = scl_low_q;
  assign link.host_sda_oe = sda_low_q;
endmodule

`default_nettype wire

// file: bench/tha_link_monitor.sv
// Checker of the link wires, fed from the interface's own signals.
// Assumes one clock for both ends and a synchronous active-high reset.
`default_nettype none
module tha_link_monitor (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic dev_attn_oe,
  input wire logic host_scl_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Wire relations
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  sequence s_rel; $fell(i_srst); endsequence
  sequence s_start; scl && $fell(sda); endsequence
  property p_rel; s_rel |-> !dev_scl_oe && !dev_sda_oe && !dev_attn_oe; endproperty
  property p_on; s_rel |-> ##[1:3] dev_attn_oe; endproperty
  property p_hold; dev_attn_oe |=> dev_attn_oe; endproperty
  property p_od; !dev_scl_o && !dev_sda_o; endproperty
  // Stretch may only extend a low phase that the host began
  property p_str; $rose(dev_scl_oe) |-> !$past(scl) && $past(host_scl_oe); endproperty
  property p_sda; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
  property p_ack; $rose(dev_sda_oe) |-> !$past(scl); endproperty
  property p_addr; s_start |-> !dev_sda_oe [*8]; endproperty
  a_rel: assert property (p_rel) else $error("pins driven at release");
  a_on: assert property (p_on) else $error("attention not driven");
  a_hold: assert property (p_hold) else $error("attention let go");
  a_od: assert property (p_od) else $error("push-pull on bus");
  a_str: assert property (p_str) else $error("bad stretch start");
  a_sda: assert property (p_sda) else $error("data moved in high");
  a_ack: assert property (p_ack) else $error("data driven in high");
  a_addr: assert property (p_addr) else $error("driven during address");
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Bench top: both ends face each other; the host is driven through its register port.
// Assumes one 100 MHz clock for both ends and a shortened byte timeout.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Pins named as the ports, so .* joins them
  logic       i_ref_clk, i_srst, i_scan_done, i_finger, i_core_busy, i_sleep, i_rpt_wr;
  logic       i_wr, i_rd, o_irq, o_wake, o_slow_scan, woke;
  logic [5:0] i_rpt_addr;
  logic [7:0] i_rpt_data, i_wdata, o_rdata, rq;
  logic [4:0] i_addr;
  int         mismatches, total_checks;
  tha_link_if link ();
  tha_device #(.TMO_CYC(40000)) tha_device_inst (.*, .link(link.device));
  tha_host tha_host_inst (.*, .link(link.host));
  tha_link_monitor tha_link_monitor_inst (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
    .dev_scl_o(link.dev_scl_o), .dev_scl_oe(link.dev_scl_oe), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe(link.dev_sda_oe), .dev_attn_oe(link.dev_attn_oe),
    .host_scl_oe(link.host_scl_oe), .scl(link.scl), .sda(link.sda));
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) woke <= !i_srst && (woke || o_wake);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string nm);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic hw(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic hr(input logic [4:0] a);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(posedge i_ref_clk);
    rq = o_rdata;
  endtask
  task automatic rpt(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_rpt_addr <= a;
    i_rpt_data <= d;
    i_rpt_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_rpt_wr <= 1'b0;
  endtask
  // Whole bus transaction, ended by the done interrupt
  task automatic xfer(input logic [7:0] p, input logic [7:0] d, input logic r);
    hw(tha_pkg::HREG_PTR, p);
    hw(tha_pkg::HREG_WDATA, d);
    hw(tha_pkg::HREG_CTRL, {6'h00, r, 1'b1});
    for (int i = 0; i < 30000 && o_irq !== 1'b1; i++) @(posedge i_ref_clk);
    hr(tha_pkg::HREG_IRQ_STAT);
    chk(rq & 8'h03, 8'h01, "ack");
    hw(tha_pkg::HREG_IRQ_STAT, 8'h07);
    @(posedge i_ref_clk);
    chk({7'h00, o_irq}, 8'h00, "irq");
    hr(tha_pkg::HREG_RDATA);
  endtask
  task automatic scan;
    @(posedge i_ref_clk);
    i_scan_done <= 1'b1;
    @(posedge i_ref_clk);
    i_scan_done <= 1'b0;
  endtask
  task automatic att(input int n, input logic e);
    repeat (n) @(posedge i_ref_clk);
    chk({7'h00, link.attn}, {7'h00, e}, "attn");
  endtask
  task automatic t_reg;
    hw(tha_pkg::HREG_IRQ_MASK, 8'h01);
    hr(tha_pkg::HREG_IRQ_MASK);
    chk(rq, 8'h01, "mask");
    hr(5'h1E);
    chk(rq, 8'h00, "unmapped");
    rpt(6'h02, 8'hA5);
    i_sleep <= 1'b1;
    xfer(8'h02, 8'h00, 1'b1);
    chk(rq, 8'hA5, "data");
    chk({7'h00, woke}, 8'h01, "wake");
    i_sleep <= 1'b0;
  endtask
  task automatic t_pulse;
    scan;
    att(500, 1'b0);
    att(600, 1'b1);
    xfer(8'h34, 8'h04, 1'b0);
    xfer(8'h35, 8'h02, 1'b0);
    scan;
    att(100, 1'b1);
    att(200, 1'b0);
  endtask
  task automatic t_modes;
    logic [7:0] m [3] = '{8'h05, 8'h07, 8'h06};
    foreach (m[i]) begin
      xfer(8'h34, m[i], 1'b0);
      i_finger <= 1'b1;
      scan;
      att(100, 1'b1);
      att(200, m[i][1] & ~m[i][0]);
      i_finger <= 1'b0;
      scan;
      att(100, 1'b1);
      i_core_busy <= 1'b1;
      fork
        begin
          repeat (1000) @(posedge i_ref_clk);
          i_core_busy <= 1'b0;
        end
      join_none
      xfer(8'h00, 8'h00, 1'b1);
      chk(rq, 8'h00, "count");
      scan;
      att(100, 1'b0);
      chk({7'h00, o_slow_scan}, 8'h01, "slow");
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Expected run is near 80k cycles
  initial begin
    repeat (100000) @(posedge i_ref_clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    i_srst = 1'b1;
    {i_scan_done, i_finger, i_core_busy, i_sleep, i_rpt_wr, i_wr, i_rd} = 7'h00;
    {i_rpt_addr, i_rpt_data, i_wdata, i_addr} = 27'h0;
    repeat (12) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    rpt(6'h00, 8'h00);
    t_reg();
    t_pulse();
    t_modes();
    give_verdict();
  end
endmodule
`default_nettype wire
